// File: design/sltp_core.sv
// Secure link table processor: tables, host commands, inbound checks, outbound securing
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Payload protection per entry: none, variant AES 128, or AES CBC.
// - Rolling counter per entry: none, two bytes or three bytes.
// - Signature per entry: none, three-byte or four-byte.
// - Teach-in accepted plain or protected by the preshared key.
// - Separate inbound and outbound tables hold key, counter and format.
// - Inbound entries found by index or by sender identifier.
// - Outbound entries found by index, destination, or own identifier.
// - Each table numbers its entries independently from zero.
// - Teach-in from unknown senders accepted only while learn state is on.
// - Successful teach-in passed whole to host as packet type 10.
// - Telegrams from unknown senders that match no filter forwarded unmodified as type 10.
// - Outside learn state, teach-in from unknown senders is discarded.
// - Known sender teach-in with correct key overwrites its counter.
// - Known sender teach-in with wrong key raises the security alert.
// - Implicit counters tracked; default window tests 128 values.
// - Host command enables or disables an extended window for next telegram.
// - Failed signatures counted; alert raised when threshold is reached.
// - Filter rules are volatile and independent of security checks.
// - Matching transmissions are secured per outbound entry automatically.
// - Failure threshold is one byte with default 100.
// - Each table holds up to 30 remote devices.
module sltp_core (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire sltp_pkg::sltp_rx_t     rx,
  input  wire sltp_pkg::sltp_tx_req_t tx_req,
  output sltp_pkg::sltp_host_t       host_out,
  output sltp_pkg::sltp_tx_sec_t     tx_sec,
  output logic                       teach_tx_valid,
  output logic [4:0]                 teach_tx_index
);
  localparam int N = sltp_pkg::ENTRIES;

  // Lowest set bit of a hit or free vector
  function automatic logic [4:0] first_one(input logic [N-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : first_one

  // Tables, indexed from zero in each direction
  logic [31:0]  in_id    [N];
  logic [127:0] in_key   [N];
  logic [23:0]  in_ctr   [N];
  logic [7:0]   in_slf   [N];
  logic [7:0]   in_fail  [N];
  logic [N-1:0] in_used;
  logic [N-1:0] in_ext;
  logic [31:0]  out_id   [N];
  logic [127:0] out_key  [N];
  logic [23:0]  out_ctr  [N];
  logic [7:0]   out_slf  [N];
  logic [N-1:0] out_used;
  logic [31:0]  filt     [sltp_pkg::FILTERS];
  logic [3:0]   filt_n;

  // Software-visible registers
  logic         learn;
  logic         psk_loaded;
  logic         cmd_ok;
  logic [127:0] psk;
  logic [31:0]  arg_id;
  logic [7:0]   arg_slf;
  logic [23:0]  arg_ctr;
  logic [127:0] arg_key;
  logic [7:0]   thresh;
  logic [31:0]  own_id;
  logic [31:0]  rd_id;
  logic [7:0]   rd_slf;
  logic [23:0]  rd_ctr;

  // Bus decode; write lands at the access edge with pready high
  wire         wr_en   = psel & penable & pready & pwrite;
  wire         setup   = psel & ~penable;
  wire         key_sel = paddr >= sltp_pkg::OFS_KEY0 && paddr < sltp_pkg::OFS_THRESH;
  wire [1:0]   key_w   = 2'(paddr[3:2] - sltp_pkg::OFS_KEY0[3:2]);
  wire         cmd_wr  = wr_en && paddr == sltp_pkg::OFS_CMD;
  wire [3:0]   cmd     = pwdata[3:0];
  wire         cmd_out = pwdata[sltp_pkg::CMD_DIR_BIT];
  wire         cmd_flg = pwdata[sltp_pkg::CMD_FLAG_BIT];
  wire [4:0]   cmd_idx = pwdata[sltp_pkg::CMD_IDX_LSB +: 5];
  wire         idx_ok  = cmd_idx < 5'(N);

  // Match vectors for every lookup key
  wire  [N-1:0] rx_hit, arg_in_hit, arg_out_hit, tx_hit, filt_hit_v;
  wire  [31:0]  tx_id = tx_req.addressed ? tx_req.dest : own_id;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_match
      assign rx_hit[g]      = in_used[g] && in_id[g] == rx.sender;
      assign arg_in_hit[g]  = in_used[g] && in_id[g] == arg_id;
      assign arg_out_hit[g] = out_used[g] && out_id[g] == arg_id;
      assign tx_hit[g]      = out_used[g] && out_id[g] == tx_id;
    end
    for (g = 0; g < sltp_pkg::FILTERS; g++) begin : g_filt
      assign filt_hit_v[g] = 4'(g) < filt_n && filt[g] == rx.sender;
    end
  endgenerate
  assign filt_hit_v[N-1:sltp_pkg::FILTERS] = '0;

  // Slot selection for commands and learning
  wire [4:0] ai_idx   = first_one(arg_in_hit);
  wire [4:0] ao_idx   = first_one(arg_out_hit);
  wire [4:0] in_free  = first_one(~in_used);
  wire [4:0] out_free = first_one(~out_used);
  wire [4:0] add_in   = |arg_in_hit ? ai_idx : in_free;
  wire [4:0] add_out  = |arg_out_hit ? ao_idx : out_free;
  wire       add_ok   = cmd_out ? (|arg_out_hit || ~&out_used)
                                : (|arg_in_hit || ~&in_used);

  // Inbound verdict
  wire [4:0]  ri      = first_one(rx_hit);
  wire        known   = |rx_hit;
  wire [23:0] diff    = rx.ctr - in_ctr[ri];
  wire [23:0] win     = in_ext[ri] ? sltp_pkg::WIN_EXTENDED
                                   : sltp_pkg::WIN_DEFAULT;
  wire [1:0]  ctr_md  = in_slf[ri][sltp_pkg::SLF_CTR_LSB +: 2];
  wire        ctr_ok  = ctr_md == 2'h0 || (diff != 24'h0 && diff <= win);
  wire        good    = rx.sig_ok & ctr_ok;
  wire [7:0]  fail_nx = in_fail[ri] + 8'h01;
  wire        thr_hit = fail_nx >= thresh;
  wire        rx_sec  = rx.valid & known & ~rx.teach;
  wire        rx_resy = rx.valid & known & rx.teach;
  wire        learn_ok = learn & (~rx.psk_prot | psk_loaded) & ~&in_used;
  wire        rx_learn = rx.valid & ~known & rx.teach & learn_ok;
  wire        rx_fwd  = rx.valid & ~known & ~rx.teach & ~|filt_hit_v;
  wire        alert   = (rx_resy & ~rx.key_ok) | (rx_sec & ~good & thr_hit);
  wire [4:0]  to      = first_one(tx_hit);

  // Register read mux, sampled in the setup cycle
  logic [31:0] rdata;
  logic        rd_bad;
  always_comb begin
    rdata  = 32'h0;
    rd_bad = 1'b0;
    if (key_sel) begin
      rdata = arg_key[key_w*32 +: 32];
    end else begin
      case (paddr)
        sltp_pkg::OFS_CMD:    rdata = 32'h0;
        sltp_pkg::OFS_STATUS: rdata = {20'h0, filt_n, 5'h0, cmd_ok, psk_loaded, learn};
        sltp_pkg::OFS_ARG_ID: rdata = arg_id;
        sltp_pkg::OFS_SLF:    rdata = {24'h0, arg_slf};
        sltp_pkg::OFS_CTR:    rdata = {8'h0, arg_ctr};
        sltp_pkg::OFS_THRESH: rdata = {24'h0, thresh};
        sltp_pkg::OFS_OWN_ID: rdata = own_id;
        sltp_pkg::OFS_RD_ID:  rdata = rd_id;
        sltp_pkg::OFS_RD_SLF: rdata = {24'h0, rd_slf};
        sltp_pkg::OFS_RD_CTR: rdata = {8'h0, rd_ctr};
        default:              rd_bad = 1'b1;
      endcase
    end
  end

  // Bus answer: one wait-free access phase after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & rd_bad;
      prdata  <= (setup & ~pwrite) ? rdata : 32'h0;
    end
  end

  // Argument and configuration registers; filters live in the table block below, lost on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arg_id  <= 32'h0;
      arg_slf <= 8'h00;
      arg_ctr <= 24'h0;
      arg_key <= 128'h0;
      thresh  <= sltp_pkg::THRESH_RST;
      own_id  <= sltp_pkg::OWN_ID_RST;
    end else if (wr_en) begin
      if (key_sel) begin
        arg_key[key_w*32 +: 32] <= pwdata;
      end
      case (paddr)
        sltp_pkg::OFS_ARG_ID: arg_id  <= pwdata;
        sltp_pkg::OFS_SLF:    arg_slf <= pwdata[7:0];
        sltp_pkg::OFS_CTR:    arg_ctr <= pwdata[23:0];
        sltp_pkg::OFS_THRESH: thresh  <= pwdata[7:0];
        sltp_pkg::OFS_OWN_ID: own_id  <= pwdata;
        default:              arg_id  <= arg_id;
      endcase
    end
  end

  // Host commands and inbound processing share the tables; telegram updates act last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        in_id[i]   <= 32'h0;
        in_key[i]  <= 128'h0;
        in_ctr[i]  <= 24'h0;
        in_slf[i]  <= 8'h00;
        in_fail[i] <= 8'h00;
        out_id[i]  <= 32'h0;
        out_key[i] <= 128'h0;
        out_ctr[i] <= 24'h0;
        out_slf[i] <= 8'h00;
      end
      for (int i = 0; i < sltp_pkg::FILTERS; i++) begin
        filt[i] <= 32'h0;
      end
      in_used        <= '0;
      in_ext         <= '0;
      out_used       <= '0;
      filt_n         <= 4'h0;
      learn          <= 1'b0;
      psk_loaded     <= 1'b0;
      psk            <= 128'h0;
      cmd_ok         <= 1'b0;
      rd_id          <= 32'h0;
      rd_slf         <= 8'h00;
      rd_ctr         <= 24'h0;
      teach_tx_valid <= 1'b0;
      teach_tx_index <= 5'h00;
      host_out       <= '0;
      tx_sec         <= '0;
    end else begin
      teach_tx_valid <= 1'b0;
      if (cmd_wr) begin
        cmd_ok <= 1'b1;
        case (cmd)
          sltp_pkg::CMD_LEARN: learn <= cmd_flg;
          sltp_pkg::CMD_ADD: begin
            cmd_ok <= add_ok;
            if (add_ok && cmd_out) begin
              out_id[add_out]   <= arg_id;
              out_key[add_out]  <= arg_key;
              out_ctr[add_out]  <= arg_ctr;
              out_slf[add_out]  <= arg_slf;
              out_used[add_out] <= 1'b1;
            end else if (add_ok) begin
              in_id[add_in]   <= arg_id;
              in_key[add_in]  <= arg_key;
              in_ctr[add_in]  <= arg_ctr;
              in_slf[add_in]  <= arg_slf;
              in_fail[add_in] <= 8'h00;
              in_used[add_in] <= 1'b1;
            end
          end
          sltp_pkg::CMD_DEL: begin
            cmd_ok <= cmd_out ? |arg_out_hit : |arg_in_hit;
            if (cmd_out) begin
              out_used <= out_used & ~arg_out_hit;
            end else begin
              in_used <= in_used & ~arg_in_hit;
            end
          end
          sltp_pkg::CMD_RD_INDEX: begin
            cmd_ok <= idx_ok && (cmd_out ? out_used[cmd_idx] : in_used[cmd_idx]);
            rd_id  <= cmd_out ? out_id[cmd_idx]  : in_id[cmd_idx];
            rd_slf <= cmd_out ? out_slf[cmd_idx] : in_slf[cmd_idx];
            rd_ctr <= cmd_out ? out_ctr[cmd_idx] : in_ctr[cmd_idx];
          end
          sltp_pkg::CMD_RD_ID: begin
            cmd_ok <= cmd_out ? |arg_out_hit : |arg_in_hit;
            rd_id  <= arg_id;
            rd_slf <= cmd_out ? out_slf[ao_idx] : in_slf[ai_idx];
            rd_ctr <= cmd_out ? out_ctr[ao_idx] : in_ctr[ai_idx];
          end
          sltp_pkg::CMD_PSK: begin
            psk        <= arg_key;
            psk_loaded <= 1'b1;
          end
          sltp_pkg::CMD_TEACH_TX: begin
            cmd_ok         <= |arg_out_hit;
            teach_tx_valid <= |arg_out_hit;
            teach_tx_index <= ao_idx;
          end
          sltp_pkg::CMD_EXT_WIN: in_ext <= cmd_flg ? in_used : '0;
          sltp_pkg::CMD_FILTER: begin
            cmd_ok <= filt_n < 4'(sltp_pkg::FILTERS);
            if (filt_n < 4'(sltp_pkg::FILTERS)) begin
              filt[filt_n] <= arg_id;
              filt_n       <= filt_n + 4'h1;
            end
          end
          default: cmd_ok <= 1'b0;
        endcase
      end
      // Inbound telegram
      if (rx_resy && rx.key_ok) begin
        in_ctr[ri]  <= rx.ctr;
        in_fail[ri] <= 8'h00;
      end
      if (rx_sec) begin
        in_ext[ri] <= 1'b0;
        if (good) begin
          in_ctr[ri]  <= rx.ctr;
          in_fail[ri] <= 8'h00;
        end else begin
          in_fail[ri] <= thr_hit ? 8'h00 : fail_nx;
        end
      end
      if (rx_learn) begin
        in_id[in_free]   <= rx.sender;
        in_key[in_free]  <= rx.key;
        in_ctr[in_free]  <= rx.ctr;
        in_slf[in_free]  <= rx.security_level_format;
        in_fail[in_free] <= 8'h00;
        in_used[in_free] <= 1'b1;
      end
      // Host packet: alert event wins over radio packet
      host_out.valid  <= alert | rx_learn | rx_fwd | (rx_sec & good);
      host_out.ptype  <= alert ? sltp_pkg::PKT_EVENT : sltp_pkg::PKT_RADIO;
      host_out.alert  <= alert;
      host_out.sender <= rx.sender;
      // Outbound securing, counter advances per transmitted telegram
      tx_sec.valid    <= tx_req.valid;
      tx_sec.found    <= |tx_hit;
      tx_sec.enc      <= out_slf[to][sltp_pkg::SLF_ENC_LSB +: 2];
      tx_sec.ctr_mode <= out_slf[to][sltp_pkg::SLF_CTR_LSB +: 2];
      tx_sec.mac_mode <= out_slf[to][sltp_pkg::SLF_MAC_LSB +: 2];
      tx_sec.key      <= out_key[to];
      tx_sec.ctr      <= out_ctr[to];
      if (tx_req.valid && |tx_hit) begin
        out_ctr[to] <= out_ctr[to] + 24'h1;
      end
    end
  end
endmodule : sltp_core
`default_nettype wire

// File: design/sltp_pkg.sv
// Package: constants, register map and carrier types of the secure link table processor
package sltp_pkg;
  localparam int ENTRIES = 30;
  localparam int IDXW    = 5;
  localparam int FILTERS = 10;
  localparam int FILTW   = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ARG_ID = 8'h08;
  localparam logic [7:0] OFS_SLF    = 8'h0c;
  localparam logic [7:0] OFS_CTR    = 8'h10;
  localparam logic [7:0] OFS_KEY0   = 8'h14;
  localparam logic [7:0] OFS_THRESH = 8'h24;
  localparam logic [7:0] OFS_OWN_ID = 8'h28;
  localparam logic [7:0] OFS_RD_ID  = 8'h2c;
  localparam logic [7:0] OFS_RD_SLF = 8'h30;
  localparam logic [7:0] OFS_RD_CTR = 8'h34;
  // Command word fields
  localparam int CMD_DIR_BIT  = 8;
  localparam int CMD_FLAG_BIT = 9;
  localparam int CMD_IDX_LSB  = 16;
  // Command codes
  localparam logic [3:0] CMD_LEARN    = 4'h1;
  localparam logic [3:0] CMD_ADD      = 4'h2;
  localparam logic [3:0] CMD_DEL      = 4'h3;
  localparam logic [3:0] CMD_RD_INDEX = 4'h4;
  localparam logic [3:0] CMD_RD_ID    = 4'h5;
  localparam logic [3:0] CMD_PSK      = 4'h6;
  localparam logic [3:0] CMD_TEACH_TX = 4'h7;
  localparam logic [3:0] CMD_EXT_WIN  = 4'h8;
  localparam logic [3:0] CMD_FILTER   = 4'h9;
  // Security level format fields
  localparam int SLF_ENC_LSB = 0;
  localparam int SLF_CTR_LSB = 2;
  localparam int SLF_MAC_LSB = 4;
  localparam int SLF_IMPLICIT_BIT = 6;
  // Reset values and limits
  localparam logic [7:0]  THRESH_RST = 8'h64;
  localparam logic [23:0] WIN_DEFAULT = 24'h000080;
  localparam logic [23:0] WIN_EXTENDED = 24'h008000;
  localparam logic [7:0]  PKT_RADIO = 8'h0a;
  localparam logic [7:0]  PKT_EVENT = 8'h04;
  localparam logic [31:0] OWN_ID_RST = 32'h00000000;

  typedef struct packed {
    logic         valid;
    logic         teach;
    logic         psk_prot;
    logic         key_ok;
    logic         sig_ok;
    logic [31:0]  sender;
    logic [23:0]  ctr;
    logic [7:0]   security_level_format;
    logic [127:0] key;
  } sltp_rx_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  ptype;
    logic        alert;
    logic [31:0] sender;
  } sltp_host_t;

  typedef struct packed {
    logic        valid;
    logic        addressed;
    logic [31:0] dest;
  } sltp_tx_req_t;

  typedef struct packed {
    logic         valid;
    logic         found;
    logic [1:0]   enc;
    logic [1:0]   ctr_mode;
    logic [1:0]   mac_mode;
    logic [127:0] key;
    logic [23:0]  ctr;
  } sltp_tx_sec_t;
endpackage : sltp_pkg

// File: test/sltp_core_properties.sv
// Concurrent checks on the ports of the secure link table processor
`timescale 1ns/1ns
`default_nettype none
module sltp_core_properties (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire sltp_pkg::sltp_rx_t      rx,
  input wire sltp_pkg::sltp_tx_req_t  tx_req,
  input wire sltp_pkg::sltp_host_t    host_out,
  input wire sltp_pkg::sltp_tx_sec_t  tx_sec,
  input wire logic                    teach_tx_valid,
  input wire logic [4:0]              teach_tx_index
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Command decode, so the teach pulse can be traced to its write
  wire cmd_wr    = psel && penable && pwrite && paddr == sltp_pkg::OFS_CMD;
  wire teach_cmd = cmd_wr && pwdata[3:0] == sltp_pkg::CMD_TEACH_TX;
  a_pready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_host_cause: assert property (host_out.valid |-> $past(rx.valid) &&
    host_out.sender == $past(rx.sender)) else $error("host packet without telegram");
  a_alert_event: assert property (host_out.valid && host_out.alert |->
    host_out.ptype == sltp_pkg::PKT_EVENT) else $error("alert with wrong packet type");
  a_radio_type: assert property (host_out.valid && !host_out.alert |->
    host_out.ptype == sltp_pkg::PKT_RADIO) else $error("radio packet with wrong type");
  a_tx_secured: assert property (tx_req.valid |=> tx_sec.valid)
    else $error("transmit request not answered");
  a_tx_cause: assert property (tx_sec.valid |-> $past(tx_req.valid))
    else $error("security answer without request");
  a_teach_cmd: assert property (teach_tx_valid |-> $past(teach_cmd) &&
    teach_tx_index < 5'd30) else $error("teach pulse without command");
  // Main scenarios reached
  c_alert: cover property (host_out.valid && host_out.alert);
  c_teach: cover property (teach_tx_valid);
  c_slverr: cover property (pready && pslverr);
endmodule : sltp_core_properties
bind sltp_core sltp_core_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx(rx), .tx_req(tx_req), .host_out(host_out),
  .tx_sec(tx_sec), .teach_tx_valid(teach_tx_valid), .teach_tx_index(teach_tx_index));
`default_nettype wire

// File: test/sltp_host_model.sv
// Host-side receiver model: takes packets and teach requests from the block
`timescale 1ns/1ns
`default_nettype none
module sltp_host_model (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire sltp_pkg::sltp_host_t  host_out,
  input wire logic                  teach_tx_valid,
  input wire logic [4:0]            teach_tx_index,
  output logic [7:0]                pkt_cnt,
  output logic [7:0]                alert_cnt,
  output logic [31:0]               last_sender,
  output logic [7:0]                teach_cnt,
  output logic [4:0]                teach_idx
);
  // Packets stand one cycle, so every one is taken on its own edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_cnt     <= 8'h00;
      alert_cnt   <= 8'h00;
      last_sender <= 32'h0;
      teach_cnt   <= 8'h00;
      teach_idx   <= 5'h00;
    end else begin
      if (host_out.valid) begin
        pkt_cnt     <= pkt_cnt + {7'h0, ~host_out.alert};
        alert_cnt   <= alert_cnt + {7'h0, host_out.alert};
        last_sender <= host_out.sender;
      end
      if (teach_tx_valid) begin
        teach_cnt <= teach_cnt + 8'h01;
        teach_idx <= teach_tx_index;
      end
    end
  end
endmodule : sltp_host_model
`default_nettype wire

// File: test/sltp_core_tb.sv
// Self-checking bench for the secure link table processor
`timescale 1ns/1ns
`default_nettype none
module sltp_core_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e_last, teach_tx_valid;
  logic [4:0]  teach_tx_index, teach_idx;
  logic [7:0]  pkt_cnt, alert_cnt, teach_cnt;
  logic [31:0] last_sender;
  sltp_pkg::sltp_rx_t     rx = '0;
  sltp_pkg::sltp_tx_req_t tx_req = '0;
  sltp_pkg::sltp_host_t   host_out;
  sltp_pkg::sltp_tx_sec_t tx_sec, s;
  int err_count = 0;
  int compares = 0;
  always #50 pclk = ~pclk;
  sltp_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx(rx), .tx_req(tx_req), .host_out(host_out), .tx_sec(tx_sec),
    .teach_tx_valid(teach_tx_valid), .teach_tx_index(teach_tx_index));
  sltp_host_model i_host (.pclk(pclk), .presetn(presetn), .host_out(host_out),
    .teach_tx_valid(teach_tx_valid), .teach_tx_index(teach_tx_index), .pkt_cnt(pkt_cnt),
    .alert_cnt(alert_cnt), .last_sender(last_sender), .teach_cnt(teach_cnt),
    .teach_idx(teach_idx));
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Setup, then access held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e_last = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rdc
  task automatic cmd(input logic [3:0] c, input logic dir, input logic f, input logic [4:0] i);
    wr(sltp_pkg::OFS_CMD, {11'h0, i, 6'h0, f, dir, 4'h0, c});
  endtask : cmd
  task automatic add(input logic dir, input logic [31:0] id, input logic [7:0] f,
                     input logic [23:0] c);
    wr(sltp_pkg::OFS_ARG_ID, id);
    wr(sltp_pkg::OFS_SLF, {24'h0, f});
    wr(sltp_pkg::OFS_CTR, {8'h0, c});
    cmd(sltp_pkg::CMD_ADD, dir, 1'b0, 5'h0);
  endtask : add
  // One telegram pulse, then time for the answer to land
  task automatic tele(input logic t, p, k, g, input logic [31:0] id, input logic [23:0] c);
    @(posedge pclk);
    rx <= '{valid: 1'b1, teach: t, psk_prot: p, key_ok: k, sig_ok: g, sender: id,
            ctr: c, security_level_format: 8'h20, key: 128'h1};
    @(posedge pclk);
    rx <= '0;
    repeat (2) @(posedge pclk);
  endtask : tele
  task automatic tx(input logic ad, input logic [31:0] d);
    @(posedge pclk);
    tx_req <= '{valid: 1'b1, addressed: ad, dest: d};
    @(posedge pclk);
    tx_req <= '0;
    #1 s = tx_sec;
  endtask : tx
  initial begin
    #(5000 * 100);
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("thresh", sltp_pkg::OFS_THRESH, 32'h64);
    rdc("status", sltp_pkg::OFS_STATUS, 32'h0);
    rdc("cmd reg", sltp_pkg::OFS_CMD, 32'h0);
    xfer(1'b0, 8'h3c, 32'h0);
    chk("slverr", 32'h1, {31'h0, e_last});
    $display("test reset done");
    add(1'b0, 32'h0a0a0001, 8'h20, 24'h10);
    add(1'b1, 32'h0b0b0002, 8'h26, 24'h100);
    cmd(sltp_pkg::CMD_RD_INDEX, 1'b0, 1'b0, 5'h0);
    rdc("in idx0", sltp_pkg::OFS_RD_ID, 32'h0a0a0001);
    cmd(sltp_pkg::CMD_RD_INDEX, 1'b1, 1'b0, 5'h0);
    rdc("out idx0", sltp_pkg::OFS_RD_ID, 32'h0b0b0002);
    rdc("out fmt", sltp_pkg::OFS_RD_SLF, 32'h26);
    cmd(sltp_pkg::CMD_RD_ID, 1'b0, 1'b0, 5'h0);
    rdc("in by id miss", sltp_pkg::OFS_STATUS, 32'h0);
    wr(sltp_pkg::OFS_ARG_ID, 32'h0a0a0001);
    cmd(sltp_pkg::CMD_RD_ID, 1'b0, 1'b0, 5'h0);
    rdc("in by id", sltp_pkg::OFS_STATUS, 32'h4);
    cmd(sltp_pkg::CMD_RD_INDEX, 1'b0, 1'b0, 5'd30);
    rdc("idx 30", sltp_pkg::OFS_STATUS, 32'h0);
    $display("test tables done");
    tele(1'b1, 1'b0, 1'b1, 1'b1, 32'h0c0c0003, 24'h0);
    chk("no learn", 32'h0, {24'h0, pkt_cnt});
    cmd(sltp_pkg::CMD_LEARN, 1'b0, 1'b1, 5'h0);
    rdc("learn on", sltp_pkg::OFS_STATUS, 32'h5);
    tele(1'b1, 1'b0, 1'b1, 1'b1, 32'h0c0c0003, 24'h0);
    chk("plain teach", 32'h1, {24'h0, pkt_cnt});
    wr(sltp_pkg::OFS_KEY0, 32'h5a5a5a5a);
    cmd(sltp_pkg::CMD_PSK, 1'b0, 1'b0, 5'h0);
    tele(1'b1, 1'b1, 1'b1, 1'b1, 32'h0d0d0004, 24'h0);
    chk("psk teach", 32'h2, {24'h0, pkt_cnt});
    tele(1'b0, 1'b0, 1'b0, 1'b0, 32'h0e0e0005, 24'h0);
    chk("unknown fwd", 32'h3, {24'h0, pkt_cnt});
    chk("unknown id", 32'h0e0e0005, last_sender);
    $display("test teach-in done");
    tele(1'b1, 1'b0, 1'b1, 1'b1, 32'h0a0a0001, 24'h000500);
    cmd(sltp_pkg::CMD_RD_ID, 1'b0, 1'b0, 5'h0);
    rdc("resync ctr", sltp_pkg::OFS_RD_CTR, 32'h500);
    tele(1'b1, 1'b0, 1'b0, 1'b1, 32'h0a0a0001, 24'h0);
    chk("bad key", 32'h1, {24'h0, alert_cnt});
    wr(sltp_pkg::OFS_THRESH, 32'h3);
    tele(1'b0, 1'b0, 1'b1, 1'b1, 32'h0a0a0001, 24'h0);
    repeat (2) tele(1'b0, 1'b0, 1'b1, 1'b0, 32'h0a0a0001, 24'h0);
    chk("below thresh", 32'h1, {24'h0, alert_cnt});
    tele(1'b0, 1'b0, 1'b1, 1'b0, 32'h0a0a0001, 24'h0);
    chk("at thresh", 32'h2, {24'h0, alert_cnt});
    repeat (2) tele(1'b0, 1'b0, 1'b1, 1'b0, 32'h0a0a0001, 24'h0);
    tele(1'b0, 1'b0, 1'b1, 1'b1, 32'h0a0a0001, 24'h0);
    repeat (2) tele(1'b0, 1'b0, 1'b1, 1'b0, 32'h0a0a0001, 24'h0);
    chk("count cleared", 32'h2, {24'h0, alert_cnt});
    $display("test alerts done");
    wr(sltp_pkg::OFS_ARG_ID, 32'h0f0f0006);
    cmd(sltp_pkg::CMD_FILTER, 1'b0, 1'b0, 5'h0);
    rdc("filter count", sltp_pkg::OFS_STATUS, 32'h107);
    tele(1'b0, 1'b0, 1'b0, 1'b0, 32'h0f0f0006, 24'h0);
    chk("filtered", 32'h0a0a0001, last_sender);
    cmd(sltp_pkg::CMD_EXT_WIN, 1'b0, 1'b1, 5'h0);
    rdc("ext window", sltp_pkg::OFS_STATUS, 32'h107);
    cmd(sltp_pkg::CMD_EXT_WIN, 1'b0, 1'b0, 5'h0);
    $display("test filter done");
    tx(1'b1, 32'h0b0b0002);
    chk("tx mode", 32'h126, {23'h0, s.found, 2'h0, s.mac_mode, s.ctr_mode, s.enc});
    chk("tx ctr", 32'h100, {8'h0, s.ctr});
    tx(1'b1, 32'h0b0b0002);
    chk("tx ctr next", 32'h101, {8'h0, s.ctr});
    wr(sltp_pkg::OFS_OWN_ID, 32'h0b0b0002);
    tx(1'b0, 32'h0);
    chk("broadcast", 32'h01000102, {7'h0, s.found, s.ctr});
    tx(1'b1, 32'h77);
    chk("no entry", 32'h0, {31'h0, s.found});
    wr(sltp_pkg::OFS_ARG_ID, 32'h0b0b0002);
    cmd(sltp_pkg::CMD_TEACH_TX, 1'b1, 1'b0, 5'h0);
    repeat (2) @(posedge pclk);
    chk("teach tx", 32'h100, {16'h0, teach_cnt, 3'h0, teach_idx});
    $display("test transmit done");
    end_of_test();
  end
endmodule : sltp_core_tb
`default_nettype wire
